// ### rtl/adrm_cfg.svh
// offsets, field positions, reset values and calibration and decimation counts of the register map
`ifndef ADRM_CFG_SVH
`define ADRM_CFG_SVH

// ****************************************************************
// register addresses (communications byte bits 3..0)
// ****************************************************************
`define ADRM_A_STATUS    4'h0
`define ADRM_A_MODE      4'h1
`define ADRM_A_ADC_CTRL  4'h2
`define ADRM_A_FILTER    4'h3
`define ADRM_A_DATA      4'h4
`define ADRM_A_OFFSET    4'h5
`define ADRM_A_GAIN      4'h6
`define ADRM_A_IO_CTRL   4'h7
`define ADRM_A_TEST      4'hC
`define ADRM_A_ID        4'hF

// ****************************************************************
// communications byte fields
// ****************************************************************
`define ADRM_CB_WEN      7
`define ADRM_CB_READ     6

// ****************************************************************
// status fields
// ****************************************************************
`define ADRM_ST_READY    7
`define ADRM_ST_CAL      5
`define ADRM_ST_ERR      3
`define ADRM_ST_LOCK     0

// ****************************************************************
// mode and io control fields
// ****************************************************************
`define ADRM_MODE_CHOP   7
`define ADRM_MODE_PSEUDO 4
`define ADRM_IO_P2DIR    5
`define ADRM_IO_P1DIR    4
`define ADRM_IO_P2OUT    1
`define ADRM_IO_P1OUT    0

// ****************************************************************
// reset values
// ****************************************************************
`define ADRM_RST_MODE    8'h00
`define ADRM_RST_ADC     8'h07
`define ADRM_RST_IO      8'h00
`define ADRM_RST_FILTER  8'h45
`define ADRM_RST_DATA    24'h00_0000
`define ADRM_RST_CAL     24'h00_0000
`define ADRM_RST_TEST    16'h0000

// ****************************************************************
// counts
// ****************************************************************
`define ADRM_NUM_CAL     5
`define ADRM_DECIM_MULT  11'h008

`endif

// ### rtl/adrm_pkg.sv
// types of the register map block
package adrm_pkg;

  typedef enum logic [1:0] {
    ST_COMMS,
    ST_WRITE,
    ST_READ
  } adrm_state_type;

  typedef logic [3:0]  adrm_addr_type;
  typedef logic [23:0] adrm_word_type;

endpackage

// ### rtl/adrm_ser_if.sv
// byte carrier between serial shifter and register map
interface adrm_ser_if;
  logic [7:0] rx_byte;
  logic       rx_stb;
  logic [7:0] tx_byte;

  modport shifter (output rx_byte, output rx_stb, input tx_byte);
  modport regmap  (input rx_byte, input rx_stb, output tx_byte);
endinterface

// ### rtl/adrm_shifter.sv
// serial bit shifter: bytes in on sclk rise, bytes out on sclk fall
module adrm_shifter (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // serial pins
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic din,
  output logic      dout,
  output logic      dout_oe,
  // byte side
  adrm_ser_if.shifter ser
);

  logic       sclk_q;
  logic [2:0] cnt_q;
  logic [6:0] rx_sh_q;
  logic [7:0] rx_byte_q;
  logic       rx_stb_q;
  logic [7:0] tx_sh_q;
  logic       rise;
  logic       fall;

  // ****************************************************************
  // edge detect
  // ****************************************************************
  assign rise = sclk & ~sclk_q & ~cs_n;
  assign fall = ~sclk & sclk_q & ~cs_n;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
    end
  end

  // ****************************************************************
  // receive
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= 3'h0;
      rx_sh_q   <= 7'h00;
      rx_byte_q <= 8'h00;
      rx_stb_q  <= 1'b0;
    end else begin
      rx_stb_q <= 1'b0;
      if (cs_n) begin
        cnt_q <= 3'h0;
      end else if (rise) begin
        rx_sh_q <= {rx_sh_q[5:0], din};
        cnt_q   <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          rx_byte_q <= {rx_sh_q, din};
          rx_stb_q  <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // transmit
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_sh_q <= 8'h00;
    end else if (fall) begin
      if (cnt_q == 3'h0) begin
        tx_sh_q <= ser.tx_byte;
      end else begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  assign ser.rx_byte = rx_byte_q;
  assign ser.rx_stb  = rx_stb_q;
  assign dout        = tx_sh_q[7];
  assign dout_oe     = ~cs_n;

endmodule // adrm_shifter

// ### rtl/adrm_regmap.sv
// register map and communications-register access discipline
`include "adrm_cfg.svh"

module adrm_regmap
  import adrm_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = 8'h5A  // arbitrary value
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  // converter side
  input  wire logic [23:0] conv_data,
  input  wire logic        conv_valid,
  input  wire logic        cal_busy,
  input  wire logic        err_flag,
  input  wire logic        pll_lock,
  input  wire logic        cal_offset_wr,
  input  wire logic        cal_gain_wr,
  input  wire logic [23:0] cal_value,
  // configuration out
  output logic [7:0]       mode_out,
  output logic [7:0]       adc_ctrl_out,
  output logic [7:0]       rate_divisor_field,
  output logic [10:0]      decim_factor,
  output logic [23:0]      cal_offset,
  output logic [23:0]      cal_gain,
  // port pins
  input  wire logic [1:0]  port_in,
  output logic [1:0]       port_out,
  output logic [1:0]       port_oe
);

  adrm_ser_if ser ();

  adrm_state_type state_q;
  adrm_addr_type  addr_q;
  logic [1:0]     left_q;
  logic [23:0]    rd_q;
  logic [15:0]    wr_q;
  logic [7:0]     mode_q;
  logic [7:0]     adc_q;
  logic [7:0]     io_q;
  logic [7:0]     filter_q;
  logic [15:0]    test_q;
  logic [23:0]    data_q;
  logic           ready_q;
  logic [23:0]    offset_q [`ADRM_NUM_CAL];
  logic [23:0]    gain_q   [`ADRM_NUM_CAL];
  logic [2:0]     cidx;
  logic [7:0]     status;
  logic [7:0]     cb;
  logic           cmd_stb;
  logic           commit;
  logic [23:0]    wr_val;
  logic           data_read;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [1:0] reg_bytes(input adrm_addr_type a);
    unique case (a)
      `ADRM_A_DATA, `ADRM_A_OFFSET, `ADRM_A_GAIN: reg_bytes = 2'd3;
      `ADRM_A_TEST:                               reg_bytes = 2'd2;
      default:                                    reg_bytes = 2'd1;
    endcase
  endfunction

  function automatic logic writable(input adrm_addr_type a);
    unique case (a)
      `ADRM_A_MODE, `ADRM_A_ADC_CTRL, `ADRM_A_FILTER, `ADRM_A_OFFSET,
      `ADRM_A_GAIN, `ADRM_A_IO_CTRL, `ADRM_A_TEST: writable = 1'b1;
      default:                                    writable = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] chan_index(input logic [3:0] ch,
                                            input logic       pseudo);
    logic [3:0] c;
    c = pseudo ? {1'b0, ch[3:1]} : ch;
    if (c > 4'd4) begin
      chan_index = 3'd4;
    end else begin
      chan_index = c[2:0];
    end
  endfunction

  // ****************************************************************
  // serial shifter
  // ****************************************************************
  adrm_shifter adrm_shifter_i (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cs_n    (cs_n),
    .sclk    (sclk),
    .din     (din),
    .dout    (dout),
    .dout_oe (dout_oe),
    .ser     (ser.shifter)
  );

  assign ser.tx_byte = rd_q[23:16];
  assign cb          = ser.rx_byte;
  assign cmd_stb     = ser.rx_stb && (state_q == ST_COMMS)
                       && !cb[`ADRM_CB_WEN];
  assign cidx        = chan_index(adc_q[7:4], mode_q[`ADRM_MODE_PSEUDO]);
  assign status      = {ready_q, 1'b0, cal_busy, 1'b0,
                        err_flag, 2'b00, pll_lock};
  assign data_read   = cmd_stb && cb[`ADRM_CB_READ]
                       && (cb[3:0] == `ADRM_A_DATA);
  assign commit      = ser.rx_stb && (state_q == ST_WRITE)
                       && (left_q == 2'd1);
  assign wr_val      = {wr_q, ser.rx_byte};

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_COMMS;
      addr_q  <= 4'h0;
      left_q  <= 2'd0;
    end else if (ser.rx_stb) begin
      unique case (state_q)
        ST_COMMS: begin
          if (!cb[`ADRM_CB_WEN]) begin
            addr_q <= cb[3:0];
            left_q <= reg_bytes(cb[3:0]);
            if (cb[`ADRM_CB_READ]) begin
              state_q <= ST_READ;
            end else if (writable(cb[3:0])) begin
              state_q <= ST_WRITE;
            end else begin
              state_q <= ST_COMMS;
            end
          end
        end
        ST_READ, ST_WRITE: begin
          left_q <= left_q - 2'd1;
          if (left_q == 2'd1) begin
            state_q <= ST_COMMS;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // read shift and write assembly
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_q <= 24'h00_0000;
    end else if (cmd_stb && cb[`ADRM_CB_READ]) begin
      unique case (cb[3:0])
        `ADRM_A_STATUS:   rd_q <= {status, 16'h0000};
        `ADRM_A_MODE:     rd_q <= {mode_q, 16'h0000};
        `ADRM_A_ADC_CTRL: rd_q <= {adc_q, 16'h0000};
        `ADRM_A_FILTER:   rd_q <= {filter_q, 16'h0000};
        `ADRM_A_DATA:     rd_q <= data_q;
        `ADRM_A_OFFSET:   rd_q <= offset_q[cidx];
        `ADRM_A_GAIN:     rd_q <= gain_q[cidx];
        `ADRM_A_IO_CTRL:  rd_q <= {io_q[7:2], port_in, 16'h0000};
        `ADRM_A_TEST:     rd_q <= {test_q, 8'h00};
        `ADRM_A_ID:       rd_q <= {ID_VALUE, 16'h0000};
        default:          rd_q <= 24'h00_0000;
      endcase
    end else if (ser.rx_stb && state_q == ST_READ) begin
      rd_q <= {rd_q[15:0], 8'h00};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= 16'h0000;
    end else if (cmd_stb) begin
      wr_q <= 16'h0000;
    end else if (ser.rx_stb && state_q == ST_WRITE) begin
      wr_q <= wr_val[15:0];
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q   <= `ADRM_RST_MODE;
      adc_q    <= `ADRM_RST_ADC;
      io_q     <= `ADRM_RST_IO;
      filter_q <= `ADRM_RST_FILTER;
      test_q   <= `ADRM_RST_TEST;
    end else if (commit) begin
      unique case (addr_q)
        `ADRM_A_MODE:     mode_q   <= wr_val[7:0];
        `ADRM_A_ADC_CTRL: adc_q    <= wr_val[7:0];
        `ADRM_A_IO_CTRL:  io_q     <= wr_val[7:0];
        `ADRM_A_FILTER:   filter_q <= wr_val[7:0];
        `ADRM_A_TEST:     test_q   <= wr_val[15:0];
        default:          test_q   <= test_q;
      endcase
    end
  end

  // ****************************************************************
  // calibration banks
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `ADRM_NUM_CAL; i++) begin
        offset_q[i] <= `ADRM_RST_CAL;
        gain_q[i]   <= `ADRM_RST_CAL;
      end
    end else begin
      if (commit && addr_q == `ADRM_A_OFFSET) begin
        offset_q[cidx] <= wr_val;
      end else if (cal_offset_wr) begin
        offset_q[cidx] <= cal_value;
      end
      if (commit && addr_q == `ADRM_A_GAIN) begin
        gain_q[cidx] <= wr_val;
      end else if (cal_gain_wr) begin
        gain_q[cidx] <= cal_value;
      end
    end
  end

  // ****************************************************************
  // result and ready flag
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_q  <= `ADRM_RST_DATA;
      ready_q <= 1'b0;
    end else begin
      if (conv_valid) begin
        data_q  <= conv_data;
        ready_q <= 1'b1;
      end else if (data_read) begin
        ready_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign mode_out           = mode_q;
  assign adc_ctrl_out       = adc_q;
  assign rate_divisor_field = filter_q;
  assign decim_factor       = 11'({3'b000, filter_q} * `ADRM_DECIM_MULT);
  assign cal_offset         = offset_q[cidx];
  assign cal_gain           = gain_q[cidx];
  assign port_out = {io_q[`ADRM_IO_P2OUT], io_q[`ADRM_IO_P1OUT]};
  assign port_oe  = {io_q[`ADRM_IO_P2DIR], io_q[`ADRM_IO_P1DIR]};

endmodule // adrm_regmap

// ### tb/adrm_regmap_properties.sv
// concurrent checks on the register map ports
module adrm_regmap_properties (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // serial pins
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        dout,
  input wire logic        dout_oe,
  // calibration inputs
  input wire logic        cal_offset_wr,
  input wire logic        cal_gain_wr,
  input wire logic [23:0] cal_value,
  // configuration outputs
  input wire logic [7:0]  mode_out,
  input wire logic [7:0]  adc_ctrl_out,
  input wire logic [7:0]  rate_divisor_field,
  input wire logic [10:0] decim_factor,
  input wire logic [23:0] cal_offset,
  input wire logic [23:0] cal_gain,
  input wire logic [1:0]  port_out,
  input wire logic [1:0]  port_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_reset_vals;
    $fell(rst) |-> mode_out == 8'h00 && adc_ctrl_out == 8'h07 &&
      rate_divisor_field == 8'h45 && port_oe == 2'b00;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset contents wrong");
  property p_decim;
    decim_factor == {rate_divisor_field, 3'b000};
  endproperty
  a_decim: assert property (p_decim)
    else $error("decimation factor not divisor times eight");
  property p_dout_oe;
    dout_oe == !cs_n;
  endproperty
  a_dout_oe: assert property (p_dout_oe)
    else $error("data out enable wrong");
  property p_dout_fall;
    $changed(dout) |-> !sclk || cs_n || $past(cs_n);
  endproperty
  a_dout_fall: assert property (p_dout_fall)
    else $error("data out moved while clock high");
  property p_mode_hold;
    cs_n && $past(cs_n) && $past(cs_n, 2) |-> $stable(mode_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed without access");
  property p_adc_hold;
    cs_n [*3] |-> $stable(adc_ctrl_out);
  endproperty
  a_adc_hold: assert property (p_adc_hold)
    else $error("adc control changed without access");
  property p_filter_hold;
    $changed(rate_divisor_field) |-> !cs_n && !$past(cs_n);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filter changed without access");
  property p_io_hold;
    $changed({port_out, port_oe}) |-> !cs_n;
  endproperty
  a_io_hold: assert property (p_io_hold)
    else $error("port pins changed without access");
  property p_off_load;
    cal_offset_wr && cs_n && $past(cs_n) |=> cal_offset == $past(cal_value);
  endproperty
  a_off_load: assert property (p_off_load)
    else $error("offset slot not loaded");
  property p_gain_load;
    cal_gain_wr && cs_n && $past(cs_n) ##1 1'b1 |-> cal_gain == $past(cal_value);
  endproperty
  a_gain_load: assert property (p_gain_load)
    else $error("gain slot not loaded");
endmodule  // adrm_regmap_properties

bind adrm_regmap adrm_regmap_properties adrm_regmap_properties_i (
  .sys_clk, .rst, .cs_n, .sclk, .dout, .dout_oe, .cal_offset_wr, .cal_gain_wr,
  .cal_value, .mode_out, .adc_ctrl_out, .rate_divisor_field, .decim_factor,
  .cal_offset, .cal_gain, .port_out, .port_oe);

// ### tb/adrm_host_model.sv
// host model: serial master opening each access with a comms byte
module adrm_host_model (
  // clock
  input  wire logic sys_clk,
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end
  // one byte msb first: drive on fall, sample on rise
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge sys_clk);
      sclk = 1'b0;
      din  = tx[i];
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
      @(posedge sys_clk);
      rx[i] = dout;
      repeat (3) @(negedge sys_clk);
    end
  endtask
  // comms byte, then nb data bytes under one select
  task automatic access(input logic [7:0] comms, input int nb,
                        input logic [23:0] wd, output logic [23:0] rd);
    logic [7:0] b;
    @(negedge sys_clk);
    cs_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    shift_byte(comms, b);
    rd = 24'h00_0000;
    for (int k = nb - 1; k >= 0; k--) begin
      shift_byte(wd[8*k +: 8], b);
      rd[8*k +: 8] = b;
    end
    repeat (2) @(negedge sys_clk);
    cs_n = 1'b1;
    din  = ~din;
  endtask
endmodule  // adrm_host_model

// ### tb/adrm_regmap_bench.sv
// self-checking bench of the register map
module adrm_regmap_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // signals
  // ********
  localparam logic [7:0] ID_VAL = 8'hA3;  // arbitrary value
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n, sclk, din, dout, dout_oe;
  logic        conv_valid = 1'b0, cal_busy = 1'b0, err_flag = 1'b0;
  logic        pll_lock = 1'b1, cal_offset_wr = 1'b0, cal_gain_wr = 1'b0;
  logic [23:0] conv_data = 24'h00_0000, cal_value = 24'h00_0000;
  logic [23:0] cal_offset, cal_gain, r;
  logic [7:0]  mode_out, adc_ctrl_out, rate_divisor_field;
  logic [10:0] decim_factor;
  logic [1:0]  port_in = 2'b00, port_out, port_oe;
  int          n_errors = 0, check_count = 0;
  logic [3:0]  ta [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                           4'hC, 4'hF};
  int          tn [10] = '{1, 1, 1, 1, 3, 3, 3, 1, 2, 1};
  logic [23:0] tv [10] = '{24'h00_0001, 24'h00_0000, 24'h00_0007,
    24'h00_0045, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000,
    24'h00_0000, {16'h0000, ID_VAL}};
  logic [7:0]  drop [5] = '{8'h00, 8'h04, 8'h0F, 8'h08, 8'h80};

  always #20 sys_clk = ~sys_clk;

  adrm_regmap #(.ID_VALUE(ID_VAL)) adrm_regmap_i (
    .sys_clk, .rst, .cs_n, .sclk, .din, .dout, .dout_oe, .conv_data,
    .conv_valid, .cal_busy, .err_flag, .pll_lock, .cal_offset_wr,
    .cal_gain_wr, .cal_value, .mode_out, .adc_ctrl_out, .rate_divisor_field,
    .decim_factor, .cal_offset, .cal_gain, .port_in, .port_out, .port_oe);
  adrm_host_model adrm_host_model_i (.sys_clk, .cs_n, .sclk, .din, .dout);
  // ********
  // tasks
  // ********
  task automatic chk(input string w, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input int nb, input logic [23:0] d);
    logic [23:0] q;
    adrm_host_model_i.access({4'h0, a}, nb, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input int nb, input logic [23:0] e,
                    input string w);
    logic [23:0] q;
    adrm_host_model_i.access({4'h4, a}, nb, 24'h00_0000, q);
    chk(w, e, q);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    finish_test();
  end
  // ********
  // tests
  // ********
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("decim_reset", 24'h00_0228, {13'h0000, decim_factor});
    foreach (ta[i]) begin
      rd(ta[i], tn[i], tv[i], "reset_value");
    end
    $display("test done: reset contents");
    wr(4'h1, 1, 24'h00_0080);
    chk("mode_out", 24'h00_0080, {16'h0000, mode_out});
    wr(4'h3, 1, 24'h00_0003);
    chk("decim_low", 24'h00_0018, {13'h0000, decim_factor});
    wr(4'h3, 1, 24'h00_00FF);
    chk("decim_high", 24'h00_07F8, {13'h0000, decim_factor});
    rd(4'h3, 1, 24'h00_00FF, "filter");
    wr(4'h2, 1, 24'h00_002F);
    rd(4'h2, 1, 24'h00_002F, "adc_ctrl");
    chk("adc_ctrl_out", 24'h00_002F, {16'h0000, adc_ctrl_out});
    port_in = 2'b10;
    wr(4'h7, 1, 24'h00_0031);
    chk("port_pins", 24'h00_000D, {20'h0_0000, port_oe, port_out});
    rd(4'h7, 1, 24'h00_0032, "io_ctrl");
    $display("test done: read and write");
    wr(4'h5, 3, 24'h12_3456);
    chk("offset_ch2", 24'h12_3456, cal_offset);
    wr(4'h2, 1, 24'h00_003F);
    chk("offset_ch3", 24'h00_0000, cal_offset);
    wr(4'h1, 1, 24'h00_0090);
    wr(4'h2, 1, 24'h00_005F);
    chk("offset_shared", 24'h12_3456, cal_offset);
    @(negedge sys_clk);
    cal_value = 24'h65_4321;
    cal_gain_wr = 1'b1;
    @(negedge sys_clk);
    cal_gain_wr = 1'b0;
    cal_value = 24'h0A_BCDE;
    cal_offset_wr = 1'b1;
    @(negedge sys_clk);
    cal_offset_wr = 1'b0;
    @(negedge sys_clk);
    chk("gain_out", 24'h65_4321, cal_gain);
    rd(4'h6, 3, 24'h65_4321, "gain");
    rd(4'h5, 3, 24'h0A_BCDE, "offset");
    wr(4'h2, 1, 24'h00_000F);
    chk("gain_ch0", 24'h00_0000, cal_gain);
    $display("test done: calibration slots");
    conv_data = 24'hAB_CDEF;
    cal_busy = 1'b1;
    err_flag = 1'b1;
    conv_valid = 1'b1;
    @(negedge sys_clk);
    conv_valid = 1'b0;
    rd(4'h0, 1, 24'h00_00A9, "status_ready");
    rd(4'h4, 3, 24'hAB_CDEF, "data");
    rd(4'h0, 1, 24'h00_0029, "status_clear");
    $display("test done: data and status");
    foreach (drop[i]) begin
      adrm_host_model_i.access(drop[i], 2, 24'h00_4300, r);
      chk("rearm_filter", 24'h00_00FF, {16'h0000, r[7:0]});
    end
    rd(4'h4, 3, 24'hAB_CDEF, "data_kept");
    rd(4'h0, 1, 24'h00_0029, "status_kept");
    rd(4'hF, 1, {16'h0000, ID_VAL}, "id_kept");
    $display("test done: refused writes");
    adrm_host_model_i.access(8'h03, 0, 24'h00_0000, r);
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    rd(4'h3, 1, 24'h00_0045, "filter_after_reset");
    rd(4'h4, 3, 24'h00_0000, "data_after_reset");
    rd(4'h0, 1, 24'h00_0029, "status_after_reset");
    $display("test done: reset mid access");
    finish_test();
  end
endmodule  // adrm_regmap_bench
